/* elc_pkg.sv */
package elc_pkg;
   localparam int          NUM_CHAN        = 7;
   localparam int          REG_W           = 8;
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  ADDR_GLOBAL     = 4'h0;
   localparam logic [3:0]  ADDR_LOCAL_LB   = 4'h1;
   localparam logic [3:0]  ADDR_REMOTE_LB  = 4'h2;
   localparam logic [3:0]  ADDR_ANALOG_LB  = 4'h3;
   localparam logic [3:0]  ADDR_TX_ONES    = 4'h4;
   localparam logic [3:0]  ADDR_RX_ONES    = 4'h5;
   localparam logic [3:0]  ADDR_TX_PDN     = 4'h6;
   localparam logic [3:0]  ADDR_SPARE      = 4'h7;
   localparam int          BIT_AUTO_ONES   = 6;
   localparam int          BIT_EXT_LOSS    = 5;
   localparam int          BIT_MUTE        = 4;
   localparam int          BIT_RAIL        = 3;
   localparam int          BIT_CODE        = 2;
   localparam int          BIT_RX_EDGE     = 1;
   localparam int          BIT_TX_EDGE     = 0;
   localparam logic [7:0]  REG_RESET       = 8'h00;
   localparam logic [6:0]  CHAN_RESET      = 7'h00;
   localparam logic [7:0]  GLOBAL_MASK     = 8'h7F;
   localparam int          LOSS_CNT_W      = 13;
   localparam logic [12:0] LOSS_ZEROS_NORM = 13'h0020;
   localparam logic [12:0] LOSS_ZEROS_EXT  = 13'h1000;
endpackage

/* elc_chan_if.sv */
`timescale 1ns/1ps
interface elc_chan_if;
   logic analogLoop;
   logic localLoop;
   logic remoteLoop;
   logic txOnes;
   logic rxOnes;
   logic txOff;
   logic singleRail;
   logic autoOnes;
   logic mute;
   logic signalLoss;
   modport ctrl (output analogLoop, localLoop, remoteLoop, txOnes, rxOnes, txOff,
                 singleRail, autoOnes, mute, signalLoss);
   modport chan (input analogLoop, localLoop, remoteLoop, txOnes, rxOnes, txOff,
                 singleRail, autoOnes, mute, signalLoss);
endinterface

/* elc_channel.sv */
`timescale 1ns/1ps
module elc_channel (
   input  wire logic clk,          // system clock
   input  wire logic nrst,         // async reset, active low
   elc_chan_if.chan  cfg,          // per-channel settings
   input  wire logic bitTick,      // one bit period strobe
   input  wire logic txPosIn,      // transmit p-rail or single-rail data
   input  wire logic txNegIn,      // transmit n-rail data
   input  wire logic rxLinePlus,   // received positive pulse
   input  wire logic rxLineMinus,  // received negative pulse
   input  wire logic rxViolIn,     // violation from line decoder
   output logic      linePlus,     // line driver positive pulse
   output logic      lineMinus,    // line driver negative pulse
   output logic      lineOe,       // line driver enable
   output logic      rxPosOut,     // receive positive or data output
   output logic      rxNegOut      // receive negative or violation output
);
   logic markPol_ff;
   logic onesPol_ff;
   logic txPlus_ff, txMinus_ff, rxPos_ff, rxNeg_ff;
   logic nxt_markPol, nxt_onesPol;

   // single rail data is made bipolar by plain mark alternation
   wire txMark    = txPosIn;
   wire encPlus   = cfg.singleRail ? (txMark & markPol_ff)  : txPosIn;
   wire encMinus  = cfg.singleRail ? (txMark & ~markPol_ff) : txNegIn;
   wire onesPlus  = onesPol_ff;
   wire onesMinus = ~onesPol_ff;

   // analog loop outranks remote loop, remote loop outranks transmit ones
   wire useRemote  = cfg.remoteLoop & ~cfg.analogLoop;
   wire useTxOnes  = cfg.txOnes & ~cfg.remoteLoop & ~cfg.analogLoop;
   wire selPlus    = useRemote ? rxLinePlus  : (useTxOnes ? onesPlus  : encPlus);
   wire selMinus   = useRemote ? rxLineMinus : (useTxOnes ? onesMinus : encMinus);

   // receive source: analog loop sees the driver register ahead of the power down gate, not the line input
   wire srcPlus  = cfg.analogLoop ? txPlus_ff  : (cfg.localLoop ? encPlus  : rxLinePlus);
   wire srcMinus = cfg.analogLoop ? txMinus_ff : (cfg.localLoop ? encMinus : rxLineMinus);
   wire srcViol  = (cfg.analogLoop | cfg.localLoop) ? 1'b0 : rxViolIn;
   wire dataPos  = cfg.singleRail ? (srcPlus | srcMinus) : srcPlus;
   wire dataNeg  = cfg.singleRail ? srcViol : srcMinus;

   wire loopHeld  = cfg.analogLoop | cfg.localLoop;
   wire forceOnes = ~loopHeld & (cfg.rxOnes | (cfg.autoOnes & cfg.signalLoss));
   wire forceLow  = ~loopHeld & ~cfg.autoOnes & cfg.mute & cfg.signalLoss;
   wire onesPos   = cfg.singleRail ? 1'b1 : onesPol_ff;
   wire onesNeg   = cfg.singleRail ? 1'b0 : ~onesPol_ff;
   wire outPos    = forceOnes ? onesPos : (forceLow ? 1'b0 : dataPos);
   wire outNeg    = forceOnes ? onesNeg : (forceLow ? 1'b0 : dataNeg);

   assign nxt_markPol = (bitTick & txMark) ? ~markPol_ff : markPol_ff;
   assign nxt_onesPol = bitTick ? ~onesPol_ff : onesPol_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         markPol_ff <= 1'b1;
         onesPol_ff <= 1'b1;
      end else begin
         markPol_ff <= nxt_markPol;
         onesPol_ff <= nxt_onesPol;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txPlus_ff  <= 1'b0;
         txMinus_ff <= 1'b0;
         rxPos_ff   <= 1'b0;
         rxNeg_ff   <= 1'b0;
      end else if (bitTick) begin
         txPlus_ff  <= selPlus;
         txMinus_ff <= selMinus;
         rxPos_ff   <= outPos;
         rxNeg_ff   <= outNeg;
      end
   end

   // powered down transmitter drives nothing and the pins float
   assign linePlus  = txPlus_ff  & ~cfg.txOff;
   assign lineMinus = txMinus_ff & ~cfg.txOff;
   assign lineOe    = ~cfg.txOff;
   assign rxPosOut  = rxPos_ff;
   assign rxNegOut  = rxNeg_ff;
endmodule

/* elc_line_ctrl.sv */
`timescale 1ns/1ps
module elc_line_ctrl #(
   parameter int NUM_CHAN = elc_pkg::NUM_CHAN
) (
   input  wire logic                clk,            // system clock
   input  wire logic                nrst,           // async reset, active low
   input  wire logic                regWrEn,        // register write strobe
   input  wire logic                regRdEn,        // register read strobe
   input  wire logic [3:0]          regAddr,        // register address
   input  wire logic [7:0]          regWrData,      // register write data
   output logic      [7:0]          regRdData,      // register read data
   input  wire logic [NUM_CHAN-1:0] bitTick,        // per-channel bit strobe
   input  wire logic [NUM_CHAN-1:0] txPositiveIn,   // transmit p-rail or data
   input  wire logic [NUM_CHAN-1:0] txNegativeIn,   // transmit n-rail
   input  wire logic [NUM_CHAN-1:0] rxLinePlus,     // received positive pulses
   input  wire logic [NUM_CHAN-1:0] rxLineMinus,    // received negative pulses
   input  wire logic [NUM_CHAN-1:0] rxViolIn,       // decoder violations
   output logic      [NUM_CHAN-1:0] lineOutPlus,    // line driver positive
   output logic      [NUM_CHAN-1:0] lineOutMinus,   // line driver negative
   output logic      [NUM_CHAN-1:0] lineOutOe,      // line driver enable
   output logic      [NUM_CHAN-1:0] rxPositiveOut,  // receive p-rail or data
   output logic      [NUM_CHAN-1:0] rxNegativeOut,  // receive n-rail or violation
   output logic      [NUM_CHAN-1:0] signalLoss,     // loss of signal per channel
   output logic                     codecHdb3,      // line codec uses HDB3
   output logic                     rxClockRising,  // receive data on rising edge
   output logic                     txClockRising   // transmit sampled on rising edge
);
   // the register layout has one bit per channel in seven-bit fields
   if (NUM_CHAN != elc_pkg::NUM_CHAN) begin : g_bad_chan
      $error("register layout serves exactly seven channels");
   end

   logic [7:0] global_ff;
   logic [6:0] localLoop_ff;
   logic [6:0] remoteLoop_ff;
   logic [6:0] analogLoop_ff;
   logic [6:0] txOnes_ff;
   logic [6:0] rxOnes_ff;
   logic [6:0] txPdn_ff;
   logic [7:0] rdData_ff;
   logic [7:0] nxt_rdData;

   // address decode
   wire wrGlobal = regWrEn & (regAddr == elc_pkg::ADDR_GLOBAL);
   wire wrLocal  = regWrEn & (regAddr == elc_pkg::ADDR_LOCAL_LB);
   wire wrRemote = regWrEn & (regAddr == elc_pkg::ADDR_REMOTE_LB);
   wire wrAnalog = regWrEn & (regAddr == elc_pkg::ADDR_ANALOG_LB);
   wire wrTxOnes = regWrEn & (regAddr == elc_pkg::ADDR_TX_ONES);
   wire wrRxOnes = regWrEn & (regAddr == elc_pkg::ADDR_RX_ONES);
   wire wrTxPdn  = regWrEn & (regAddr == elc_pkg::ADDR_TX_PDN);
   wire [6:0] chanBits = regWrData[6:0];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         global_ff <= elc_pkg::REG_RESET;
      end else if (wrGlobal) begin
         global_ff <= regWrData & elc_pkg::GLOBAL_MASK;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         localLoop_ff <= elc_pkg::CHAN_RESET;
      end else if (wrLocal) begin
         localLoop_ff <= chanBits;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         remoteLoop_ff <= elc_pkg::CHAN_RESET;
      end else if (wrRemote) begin
         remoteLoop_ff <= chanBits;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         analogLoop_ff <= elc_pkg::CHAN_RESET;
      end else if (wrAnalog) begin
         analogLoop_ff <= chanBits;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txOnes_ff <= elc_pkg::CHAN_RESET;
      end else if (wrTxOnes) begin
         txOnes_ff <= chanBits;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rxOnes_ff <= elc_pkg::CHAN_RESET;
      end else if (wrRxOnes) begin
         rxOnes_ff <= chanBits;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txPdn_ff <= elc_pkg::CHAN_RESET;
      end else if (wrTxPdn) begin
         txPdn_ff <= chanBits;
      end
   end

   // readback; spare and unmapped addresses read zero
   always_comb begin
      case (regAddr)
         elc_pkg::ADDR_GLOBAL:    nxt_rdData = global_ff;
         elc_pkg::ADDR_LOCAL_LB:  nxt_rdData = {1'b0, localLoop_ff};
         elc_pkg::ADDR_REMOTE_LB: nxt_rdData = {1'b0, remoteLoop_ff};
         elc_pkg::ADDR_ANALOG_LB: nxt_rdData = {1'b0, analogLoop_ff};
         elc_pkg::ADDR_TX_ONES:   nxt_rdData = {1'b0, txOnes_ff};
         elc_pkg::ADDR_RX_ONES:   nxt_rdData = {1'b0, rxOnes_ff};
         elc_pkg::ADDR_TX_PDN:    nxt_rdData = {1'b0, txPdn_ff};
         elc_pkg::ADDR_SPARE:     nxt_rdData = 8'h00;
         default:                 nxt_rdData = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdData_ff <= 8'h00;
      end else if (regRdEn) begin
         rdData_ff <= nxt_rdData;
      end
   end
   assign regRdData = rdData_ff;

   // global fields
   wire autoOnes   = global_ff[elc_pkg::BIT_AUTO_ONES];
   wire extLoss    = global_ff[elc_pkg::BIT_EXT_LOSS];
   wire muteOnLoss = global_ff[elc_pkg::BIT_MUTE];
   wire singleRail = global_ff[elc_pkg::BIT_RAIL];
   // coding choice means nothing in dual rail, so it is masked there
   assign codecHdb3     = singleRail & global_ff[elc_pkg::BIT_CODE];
   assign rxClockRising = global_ff[elc_pkg::BIT_RX_EDGE];
   assign txClockRising = global_ff[elc_pkg::BIT_TX_EDGE];

   // threshold switch takes effect on the running count, no restart
   wire [12:0] lossLimit = extLoss ? elc_pkg::LOSS_ZEROS_EXT
                                   : elc_pkg::LOSS_ZEROS_NORM;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
         logic [12:0] zeroCnt_ff;
         logic [12:0] nxt_zeroCnt;
         logic        loss_ff;
         logic        nxt_loss;
         elc_chan_if  cfg ();

         // line input is cut off in analog loop, so count the looped pulses
         wire seenMark = analogLoop_ff[ch] ? (lineOutPlus[ch] | lineOutMinus[ch])
                                           : (rxLinePlus[ch] | rxLineMinus[ch]);
         wire atLimit  = (zeroCnt_ff >= lossLimit);

         always_comb begin
            nxt_zeroCnt = zeroCnt_ff;
            nxt_loss    = loss_ff;
            if (bitTick[ch]) begin
               if (seenMark) begin
                  nxt_zeroCnt = 13'h0000;
                  nxt_loss    = 1'b0;
               end else if (!atLimit) begin
                  nxt_zeroCnt = zeroCnt_ff + 13'h0001;
                  nxt_loss    = ((zeroCnt_ff + 13'h0001) >= lossLimit);
               end else begin
                  nxt_loss    = 1'b1;
               end
            end
         end

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               zeroCnt_ff <= 13'h0000;
               loss_ff    <= 1'b0;
            end else begin
               zeroCnt_ff <= nxt_zeroCnt;
               loss_ff    <= nxt_loss;
            end
         end
         assign signalLoss[ch] = loss_ff;

         assign cfg.analogLoop = analogLoop_ff[ch];
         assign cfg.localLoop  = localLoop_ff[ch];
         assign cfg.remoteLoop = remoteLoop_ff[ch];
         assign cfg.txOnes     = txOnes_ff[ch];
         assign cfg.rxOnes     = rxOnes_ff[ch];
         assign cfg.txOff      = txPdn_ff[ch];
         assign cfg.singleRail = singleRail;
         assign cfg.autoOnes   = autoOnes;
         assign cfg.mute       = muteOnLoss;
         assign cfg.signalLoss = loss_ff;

         elc_channel u_chan (
            .clk         (clk),
            .nrst        (nrst),
            .cfg         (cfg.chan),
            .bitTick     (bitTick[ch]),
            .txPosIn     (txPositiveIn[ch]),
            .txNegIn     (txNegativeIn[ch]),
            .rxLinePlus  (rxLinePlus[ch]),
            .rxLineMinus (rxLineMinus[ch]),
            .rxViolIn    (rxViolIn[ch]),
            .linePlus    (lineOutPlus[ch]),
            .lineMinus   (lineOutMinus[ch]),
            .lineOe      (lineOutOe[ch]),
            .rxPosOut    (rxPositiveOut[ch]),
            .rxNegOut    (rxNegativeOut[ch])
         );
      end
   endgenerate
endmodule

/* elc_line_ctrl_chk.sv */
`timescale 1ns/1ps
module elc_line_ctrl_chk #(
   parameter int NUM_CHAN = 7
) (
   input wire logic                clk,           // clock
   input wire logic                nrst,          // reset
   input wire logic                regWrEn,       // write
   input wire logic                regRdEn,       // read
   input wire logic [3:0]          regAddr,       // address
   input wire logic [7:0]          regWrData,     // write data
   input wire logic [7:0]          regRdData,     // read data
   input wire logic [NUM_CHAN-1:0] bitTick,       // bit strobe
   input wire logic [NUM_CHAN-1:0] lineOutPlus,   // line plus
   input wire logic [NUM_CHAN-1:0] lineOutMinus,  // line minus
   input wire logic [NUM_CHAN-1:0] lineOutOe,     // line enable
   input wire logic [NUM_CHAN-1:0] rxPositiveOut, // rx pos
   input wire logic [NUM_CHAN-1:0] rxNegativeOut, // rx neg
   input wire logic [NUM_CHAN-1:0] signalLoss,    // loss
   input wire logic                codecHdb3,     // codec
   input wire logic                rxClockRising, // rx edge
   input wire logic                txClockRising  // tx edge
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire wrGlobal = regWrEn && regAddr == 4'h0;
   wire wrPdn    = regWrEn && regAddr == 4'h6;
   // host leaves one idle cycle between a write and the next read
   sequence wrThenRd;
      regWrEn && regAddr < 4'h7 ##1 !regWrEn
         ##1 regRdEn && !regWrEn && regAddr == $past(regAddr, 2);
   endsequence
   chk_read_back: assert property (
      wrThenRd |=> regRdData == {1'b0, $past(regWrData[6:0], 3)})
      else $error("read data differs from last write");
   chk_spare_zero: assert property (
      regRdEn && regAddr >= 4'h7 |=> regRdData == 8'h00)
      else $error("spare or unmapped read not zero");
   chk_reset_clear: assert property (
      $rose(nrst) |-> regRdData == 8'h00 && lineOutOe == '1 && !codecHdb3)
      else $error("state not cleared by reset");
   chk_oe_powerdown: assert property (
      wrPdn |=> lineOutOe == ~$past(regWrData[NUM_CHAN-1:0]))
      else $error("line enable does not follow power down");
   chk_floated_quiet: assert property (
      ((lineOutPlus | lineOutMinus) & ~lineOutOe) == '0)
      else $error("pulse on powered down line");
   chk_codec_select: assert property (
      wrGlobal |=> codecHdb3 == ($past(regWrData[3]) && $past(regWrData[2])))
      else $error("codec select wrong");
   chk_edge_select: assert property (
      wrGlobal |=> rxClockRising == $past(regWrData[1]) && txClockRising == $past(regWrData[0]))
      else $error("clock edge select wrong");
   chk_line_exclusive: assert property (
      (lineOutPlus & lineOutMinus) == '0)
      else $error("both line pulses at once");
   chk_rx_hold: assert property (
      bitTick == '0 |=> $stable(rxPositiveOut) && $stable(rxNegativeOut))
      else $error("receive output moved without a tick");
   chk_loss_on_tick: assert property (
      $rose(signalLoss[0]) |-> $past(bitTick[0]))
      else $error("loss rose without a tick");
endmodule

bind elc_line_ctrl elc_line_ctrl_chk #(.NUM_CHAN(NUM_CHAN)) chk (
   .clk, .nrst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .bitTick,
   .lineOutPlus, .lineOutMinus, .lineOutOe, .rxPositiveOut, .rxNegativeOut,
   .signalLoss, .codecHdb3, .rxClockRising, .txClockRising);

/* elc_host_model.sv */
`timescale 1ns/1ps
module elc_host_model (
   input  wire logic       clk,       // clock
   output logic            regWrEn,   // write strobe
   output logic            regRdEn,   // read strobe
   output logic [3:0]      regAddr,   // address
   output logic [7:0]      regWrData, // write data
   input  wire logic [7:0] regRdData  // read data
);
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 4'h0;
      regWrData = 8'h00;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
      // released data must not look valid
      regWrData <= ~d;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1;
      d = regRdData;
   endtask
endmodule

/* test_elc_line_ctrl.sv */
`timescale 1ns/1ps
module test_elc_line_ctrl;
   logic       clk, nrst, codecHdb3, rxClockRising, txClockRising, ph;
   wire        regWrEn, regRdEn;
   wire  [3:0] regAddr;
   wire  [7:0] regWrData;
   logic [7:0] regRdData, rdVal;
   logic [6:0] bitTick, txPositiveIn, txNegativeIn, rxLinePlus, rxLineMinus, rxViolIn;
   logic [6:0] lineOutPlus, lineOutMinus, lineOutOe, rxPositiveOut, rxNegativeOut;
   logic [6:0] signalLoss;
   int         errors, checked;

   elc_line_ctrl #(.NUM_CHAN(7)) DUT (
      .clk, .nrst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .bitTick,
      .txPositiveIn, .txNegativeIn, .rxLinePlus, .rxLineMinus, .rxViolIn,
      .lineOutPlus, .lineOutMinus, .lineOutOe, .rxPositiveOut, .rxNegativeOut,
      .signalLoss, .codecHdb3, .rxClockRising, .txClockRising);
   elc_host_model host (.clk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one bit period on every channel; outputs settle after the tick edge
   task automatic tick(input logic [6:0] tp, input logic [6:0] lp);
      @(posedge clk);
      bitTick <= 7'h7F;
      txPositiveIn <= tp;
      rxLinePlus <= lp;
      @(posedge clk);
      bitTick <= 7'h00;
      #1;
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      final_report();
   end

   initial begin
      nrst = 1'b0;
      bitTick = '0;
      txPositiveIn = '0;
      txNegativeIn = '0;
      rxLinePlus = '0;
      rxLineMinus = '0;
      rxViolIn = '0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (int a = 0; a < 9; a++) begin
         host.rd(a[3:0], rdVal);
         chk(rdVal, 8'h00);
      end
      $display("test reset values done");
      // bit 7, spare and unmapped writes must all read back as zero
      for (int a = 0; a < 9; a++) begin
         host.wr(a[3:0], 8'hF0 ^ a[7:0]);
         host.rd(a[3:0], rdVal);
         chk(rdVal, (a < 7) ? (8'h70 ^ a[7:0]) : 8'h00);
      end
      for (int a = 0; a < 7; a++) host.wr(a[3:0], 8'h00);
      $display("test read back done");
      for (int d = 0; d < 16; d++) begin
         host.wr(4'h0, d[7:0]);
         chk({codecHdb3, rxClockRising, txClockRising}, {d[3] & d[2], d[1:0]});
      end
      $display("test global selects done");
      host.wr(4'h6, 8'h85);
      chk({1'b0, lineOutOe}, 8'h7A);
      host.wr(4'h6, 8'h00);
      $display("test power down done");
      host.wr(4'h0, 8'h08);
      tick(7'h7F, 7'h00);
      chk({lineOutPlus[0], lineOutMinus[0]}, 8'h02);
      tick(7'h7F, 7'h00);
      chk({lineOutPlus[0], lineOutMinus[0]}, 8'h01);
      host.wr(4'h4, 8'h7F);
      tick(7'h00, 7'h00);
      chk({lineOutPlus[0], lineOutMinus[0]}, 8'h02);
      tick(7'h00, 7'h00);
      chk({lineOutPlus[0], lineOutMinus[0]}, 8'h01);
      host.wr(4'h2, 8'h7F);
      tick(7'h00, 7'h7F);
      chk({lineOutPlus[0], lineOutMinus[0]}, 8'h02);
      chk({rxPositiveOut[0], rxNegativeOut[0]}, 8'h02);
      host.wr(4'h2, 8'h00);
      host.wr(4'h4, 8'h00);
      $display("test transmit done");
      rxViolIn <= 7'h7F;
      host.wr(4'h1, 8'h7F);
      tick(7'h7F, 7'h00);
      chk(lineOutPlus[0] | lineOutMinus[0], 8'h01);
      tick(7'h7F, 7'h00);
      chk({rxPositiveOut[0], rxNegativeOut[0]}, 8'h02);
      host.wr(4'h5, 8'h7F);
      tick(7'h00, 7'h00);
      tick(7'h00, 7'h00);
      chk(rxPositiveOut[0], 8'h00);
      host.wr(4'h1, 8'h00);
      tick(7'h00, 7'h00);
      chk({rxPositiveOut[0], rxNegativeOut[0]}, 8'h02);
      host.wr(4'h0, 8'h00);
      tick(7'h00, 7'h00);
      ph = rxPositiveOut[0];
      chk(rxNegativeOut[0], {7'h00, ~ph});
      tick(7'h00, 7'h00);
      chk(rxPositiveOut[0], {7'h00, ~ph});
      host.wr(4'h5, 8'h00);
      $display("test loops and receive ones done");
      host.wr(4'h0, 8'h18);
      tick(7'h00, 7'h7F);
      repeat (31) tick(7'h00, 7'h00);
      chk({signalLoss[0], rxNegativeOut[0]}, 8'h01);
      tick(7'h00, 7'h00);
      chk(signalLoss[0], 8'h01);
      // receive outputs follow the loss flag one bit later
      tick(7'h00, 7'h00);
      chk({signalLoss[0], rxPositiveOut[0], rxNegativeOut[0]}, 8'h04);
      host.wr(4'h0, 8'h58);
      tick(7'h00, 7'h00);
      chk({rxPositiveOut[0], rxNegativeOut[0]}, 8'h02);
      host.wr(4'h0, 8'h28);
      tick(7'h00, 7'h7F);
      chk(signalLoss[0], 8'h00);
      repeat (4095) tick(7'h00, 7'h00);
      chk(signalLoss[0], 8'h00);
      tick(7'h00, 7'h00);
      chk(signalLoss[0], 8'h01);
      $display("test signal loss done");
      // analog loop outranks transmit ones and cuts the line input off
      host.wr(4'h0, 8'h08);
      host.wr(4'h4, 8'h7F);
      host.wr(4'h3, 8'h7F);
      tick(7'h7F, 7'h00);
      chk({lineOutPlus[0], lineOutMinus[0]}, 8'h02);
      tick(7'h00, 7'h7F);
      chk({rxPositiveOut[0], rxNegativeOut[0]}, 8'h02);
      tick(7'h00, 7'h7F);
      chk({rxPositiveOut[0], rxNegativeOut[0]}, 8'h00);
      $display("test analog loop done");
      final_report();
   end
endmodule
